// ===== verilog/ldcfg_pkg.sv
// Package with offsets, field positions and reset values of the logical device configuration bank.
package ldcfg_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  // Logical device numbers.
  localparam logic [7:0] LDN_KBD     = 8'h07;
  localparam logic [7:0] LDN_RUNTIME = 8'h0A;
  localparam logic [7:0] LDN_SMBUS   = 8'h0B;
  // Register bus: address is {logical device, index}.
  localparam int ADDR_W = 16;
  localparam logic [7:0] IDX_F0      = 8'hF0;
  localparam logic [7:0] IDX_F1      = 8'hF1;
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  // Block-local registers placed in their own logical device.
  localparam logic [7:0] LDN_LOCAL   = 8'h0E;
  localparam logic [7:0] IDX_STATUS  = 8'h00;
  localparam logic [7:0] IDX_MASK    = 8'h01;
  // Field positions.
  localparam int KBD_POL_BIT    = 7;
  localparam int KBD_MOUSE_LATCH_BIT = 4;
  localparam int KBD_KEY_LATCH_BIT   = 3;
  localparam int KBD_ALT92_BIT  = 2;
  localparam int CLK_ABSENT_BIT = 0;
  localparam int CLK_KEYOFF_BIT = 1;
  // Writable bits; the rest read as zero.
  localparam logic [7:0] KBD_MASK     = 8'h9C;
  localparam logic [7:0] CLK_MASK     = 8'h03;
  localparam logic [7:0] STEER_MASK   = 8'h03;
  localparam logic [7:0] BASE_HI_MASK = 8'h0F;
  localparam logic [7:0] BASE_LO_MASK = 8'hF8;
  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Steering field encodings.
  localparam logic [1:0] STEER_MODE_REG = 2'h0;
  localparam logic [1:0] STEER_PIN_D1   = 2'h1;
  localparam logic [1:0] STEER_PIN_D01  = 2'h2;
  // Status bit positions (events).
  localparam int EV_KBD_BIT   = 0;
  localparam int EV_MOUSE_BIT = 1;
  localparam int EV_STEER_BIT = 2;
  localparam int EV_W = 3;
endpackage : ldcfg_pkg

// ===== verilog/pin_sync_if.sv
// Interface carrying synchronised pin levels from the synchroniser to the bank.
interface pin_sync_if;
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] level;
  modport src (output level);
  modport dst (input  level);
endinterface : pin_sync_if

// ===== verilog/pin_sync.sv
// Three-stage synchroniser whose output changes once stages two and three agree.
module pin_sync
  import ldcfg_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Pins and result
  input  wire logic [3:0] pins,
  pin_sync_if.src         sync
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit only takes a new value when the two later stages agree on it.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync.level <= 4'h0;
    end else begin
      sync.level <= (s2 & s3) | (sync.level & (s2 | s3));
    end
  end
endmodule : pin_sync

// ===== verilog/irq_latch.sv
// Interrupt latch that holds a rising request until the controller drops it.
module irq_latch (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Request in, latched copy and rise pulse out
  input  wire logic raw,
  output logic      latched,
  output logic      rose
);
  timeunit 1ns;
  timeprecision 1ps;
  logic raw_d;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      raw_d   <= 1'b0;
      latched <= 1'b0;
    end else begin
      raw_d <= raw;
      if (raw && !raw_d) begin
        latched <= 1'b1;
      end else if (!raw && raw_d) begin
        latched <= 1'b0;
      end
    end
  end

  assign rose = raw && !raw_d;
endmodule : irq_latch

// ===== verilog/ldcfg_bank.sv
// Configuration register bank for the keyboard, runtime and bus management logical devices.
// Summary of operation
// (R1) Bit 7 of keyboard select sets output line polarity: 0 low, 1 high.
// (R2) Bit 4 zero gives raw mouse irq AND latched; one gives latched only.
// (R3) Bit 3 zero gives raw keyboard irq AND latched; one gives latched only.
// (R4) Bit 2 enables the alternate system control port.
// (R5) Keyboard indices F1 through FF are reserved and read zero.
// (R6) Slow clock bit 0 records clock absence; zero means present.
// (R7) Slow clock bit 1 set gates the clock off the key wake logic.
// (R8) Steering 00 leaves floppy routing to the printer port mode register.
// (R9) Steering 01 with pin low puts drive 1 on printer pins only.
// (R10) Steering 10 with pin low puts both drives on printer pins; 11 reserved.
// (R11) Software keeps the bus controller base within 0x0100 to 0x0FF8.
// (R12) Reserved bits read zero and writes to them have no effect.
module ldcfg_bank
  import ldcfg_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  // Keyboard controller side
  input  wire logic              kbc_port_line_raw,
  input  wire logic              kbd_irq_raw,
  input  wire logic              mouse_irq_raw,
  output logic                   kbc_port_output_line,
  output logic                   kbd_irq,
  output logic                   mouse_irq,
  output logic                   alt_ctrl_port_en,
  // Slow clock and key wake
  input  wire logic              slow_clock_in,
  output logic                   slow_clock_absent,
  output logic                   key_wake_logic_off,
  output logic                   key_wake_clk_en,
  // Floppy steering
  input  wire logic              steer_pin,
  input  wire logic              pp_mode_floppy_d0,
  input  wire logic              pp_mode_floppy_d1,
  output logic                   drive0_on_pp,
  output logic                   drive1_on_pp,
  // Bus management base
  output logic      [15:0]       smbus_base,
  // Interrupt
  output logic                   irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]      kbd_reset_gate_select;
  logic [7:0]      slow_clock_config;
  logic [7:0]      floppy_on_printer_steer;
  logic [7:0]      smbus_base_addr_high;
  logic [7:0]      smbus_base_addr_low;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic [7:0]      next_rdata;
  logic            kbd_latched;
  logic            mouse_latched;
  logic            kbd_rose;
  logic            mouse_rose;
  logic            steer_prev;
  logic            steer_ev;
  logic            status_rd;
  logic [EV_W-1:0] events;
  logic [4:0]      sync_warm;

  pin_sync_if pins_s ();
  pin_sync_if slow_s ();

  // Synchronised levels: 0 kbc line, 1 kbd irq, 2 mouse irq, 3 steering pin.
  pin_sync u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .pins  ({steer_pin, mouse_irq_raw, kbd_irq_raw, kbc_port_line_raw}),
    .sync  (pins_s)
  );

  // The slow clock is a pin as well; the spare synchroniser bits are tied low and unread.
  pin_sync u_slow_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .pins  ({3'h0, slow_clock_in}),
    .sync  (slow_s)
  );

  irq_latch u_kbd_latch (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .raw     (pins_s.level[1]),
    .latched (kbd_latched),
    .rose    (kbd_rose)
  );

  irq_latch u_mouse_latch (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .raw     (pins_s.level[2]),
    .latched (mouse_latched),
    .rose    (mouse_rose)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ldn,
                               input logic [7:0] idx);
    hit = (a[15:8] == ldn) && (a[7:0] == idx);
  endfunction : hit

  // Register writes; only implemented bits are stored.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      kbd_reset_gate_select   <= RST_ZERO;
      slow_clock_config       <= RST_ZERO;
      floppy_on_printer_steer <= RST_ZERO;
      smbus_base_addr_high    <= RST_ZERO;
      smbus_base_addr_low     <= RST_ZERO;
      mask                    <= '0;
    end else if (wr) begin
      if (hit(addr, LDN_KBD, IDX_F0)) begin
        kbd_reset_gate_select <= wdata & KBD_MASK; // [R12]
      end
      if (hit(addr, LDN_RUNTIME, IDX_F0)) begin
        slow_clock_config <= wdata & CLK_MASK; // [R6] [R12]
      end
      if (hit(addr, LDN_RUNTIME, IDX_F1)) begin
        floppy_on_printer_steer <= wdata & STEER_MASK; // [R12]
      end
      // The base is stored as written; keeping it in range is software's duty.
      if (hit(addr, LDN_SMBUS, IDX_BASE_HI)) begin
        smbus_base_addr_high <= wdata & BASE_HI_MASK; // [R11] [R12]
      end
      if (hit(addr, LDN_SMBUS, IDX_BASE_LO)) begin
        smbus_base_addr_low <= wdata & BASE_LO_MASK; // [R11] [R12]
      end
      if (hit(addr, LDN_LOCAL, IDX_MASK)) begin
        mask <= wdata[EV_W-1:0];
      end
    end
  end

  // Read mux; every unmapped address, keyboard F1..FF included, reads zero.
  always_comb begin
    next_rdata = 8'h00; // [R5]
    if (hit(addr, LDN_KBD, IDX_F0)) begin
      next_rdata = kbd_reset_gate_select;
    end else if (hit(addr, LDN_RUNTIME, IDX_F0)) begin
      next_rdata = slow_clock_config;
    end else if (hit(addr, LDN_RUNTIME, IDX_F1)) begin
      next_rdata = floppy_on_printer_steer;
    end else if (hit(addr, LDN_SMBUS, IDX_BASE_HI)) begin
      next_rdata = smbus_base_addr_high;
    end else if (hit(addr, LDN_SMBUS, IDX_BASE_LO)) begin
      next_rdata = smbus_base_addr_low;
    end else if (hit(addr, LDN_LOCAL, IDX_STATUS)) begin
      next_rdata = {{(8-EV_W){1'b0}}, status};
    end else if (hit(addr, LDN_LOCAL, IDX_MASK)) begin
      next_rdata = {{(8-EV_W){1'b0}}, mask};
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // Sticky events; a new event in the read cycle survives the clear.
  assign status_rd = rd && hit(addr, LDN_LOCAL, IDX_STATUS);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      steer_prev <= 1'b0;
    end else begin
      steer_prev <= pins_s.level[3];
    end
  end

  // The synchroniser leaves reset at zero while an idle steering pin sits high; without
  // this warm-up its first settled level would look like a pin change and set status.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync_warm <= 5'h00;
    end else begin
      sync_warm <= {sync_warm[3:0], 1'b1};
    end
  end

  assign steer_ev = sync_warm[4] && (pins_s.level[3] ^ steer_prev);

  always_comb begin
    events               = '0;
    events[EV_KBD_BIT]   = kbd_rose;
    events[EV_MOUSE_BIT] = mouse_rose;
    events[EV_STEER_BIT] = steer_ev;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status <= '0;
    end else begin
      status <= (status_rd ? '0 : status) | events;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // The port line idles high after reset, since its default polarity is active low.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      kbc_port_output_line <= 1'b1;
    end else if (kbd_reset_gate_select[KBD_POL_BIT]) begin
      kbc_port_output_line <= pins_s.level[0]; // [R1]
    end else begin
      kbc_port_output_line <= ~pins_s.level[0]; // [R1]
    end
  end

  // In the default mode the output drops with the raw request, in step with the latch and a cycle before latched-only mode.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mouse_irq <= 1'b0;
    end else if (kbd_reset_gate_select[KBD_MOUSE_LATCH_BIT]) begin
      mouse_irq <= mouse_latched; // [R2]
    end else begin
      mouse_irq <= pins_s.level[2] & mouse_latched; // [R2]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      kbd_irq <= 1'b0;
    end else if (kbd_reset_gate_select[KBD_KEY_LATCH_BIT]) begin
      kbd_irq <= kbd_latched; // [R3]
    end else begin
      kbd_irq <= pins_s.level[1] & kbd_latched; // [R3]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      alt_ctrl_port_en <= 1'b0;
    end else begin
      alt_ctrl_port_en <= kbd_reset_gate_select[KBD_ALT92_BIT]; // [R4]
    end
  end

  // Slow clock presence and wake logic gating.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      slow_clock_absent  <= 1'b0;
      key_wake_logic_off <= 1'b0;
      key_wake_clk_en    <= 1'b0;
    end else begin
      slow_clock_absent  <= slow_clock_config[CLK_ABSENT_BIT]; // [R6]
      key_wake_logic_off <= slow_clock_config[CLK_KEYOFF_BIT]; // [R7]
      // Enable for the wake logic's clock gate; held off when absent or switched off.
      key_wake_clk_en <= slow_s.level[0] && !slow_clock_config[CLK_KEYOFF_BIT]
                         && !slow_clock_config[CLK_ABSENT_BIT]; // [R7]
    end
  end

  // Floppy steering. The steering pin is active low; reserved 11 acts like 00.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      drive0_on_pp <= 1'b0;
      drive1_on_pp <= 1'b0;
    end else begin
      unique case (floppy_on_printer_steer[1:0])
        STEER_PIN_D1: begin
          drive0_on_pp <= 1'b0; // [R9]
          drive1_on_pp <= !pins_s.level[3]; // [R9]
        end
        STEER_PIN_D01: begin
          drive0_on_pp <= !pins_s.level[3]; // [R10]
          drive1_on_pp <= !pins_s.level[3]; // [R10]
        end
        default: begin
          drive0_on_pp <= pp_mode_floppy_d0; // [R8] [R10]
          drive1_on_pp <= pp_mode_floppy_d1; // [R8]
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      smbus_base <= 16'h0000;
    end else begin
      smbus_base <= {4'h0, smbus_base_addr_high[3:0], smbus_base_addr_low[7:3], 3'h0}; // [R11]
    end
  end
endmodule : ldcfg_bank

// ===== testbench/ldcfg_bank_monitor.sv
// Checker of port relations of the configuration bank.
module ldcfg_bank_monitor
  import ldcfg_pkg::*;
(
  // Watched ports
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0]        wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [7:0]        rdata,
  input wire logic              alt_ctrl_port_en,
  input wire logic              slow_clock_absent,
  input wire logic              key_wake_logic_off,
  input wire logic              key_wake_clk_en,
  input wire logic [15:0]       smbus_base,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  property p_rdata_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
  property p_kbd_rsvd;
    rd && addr[15:8] == LDN_KBD && addr[7:0] > IDX_F0 |=> rdata == 8'h00;
  endproperty
  a_kbd_rsvd: assert property (p_kbd_rsvd) else $error("reserved index read");
  property p_alt;
    wr && addr == {LDN_KBD, IDX_F0} |-> ##2 alt_ctrl_port_en == $past(wdata[KBD_ALT92_BIT], 2);
  endproperty
  a_alt: assert property (p_alt) else $error("alt port enable");
  property p_absent;
    wr && addr == {LDN_RUNTIME, IDX_F0}
      |-> ##2 slow_clock_absent == $past(wdata[CLK_ABSENT_BIT], 2);
  endproperty
  a_absent: assert property (p_absent) else $error("slow clock absent");
  property p_keyoff;
    wr && addr == {LDN_RUNTIME, IDX_F0}
      |-> ##2 key_wake_logic_off == $past(wdata[CLK_KEYOFF_BIT], 2);
  endproperty
  a_keyoff: assert property (p_keyoff) else $error("key wake off");
  property p_clk_gate;
    key_wake_clk_en |-> !key_wake_logic_off && !slow_clock_absent;
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("key wake clock");
  property p_base_zero;
    smbus_base[2:0] == 3'h0 && smbus_base[15:12] == 4'h0;
  endproperty
  a_base_zero: assert property (p_base_zero) else $error("base zero bits");
  property p_base_lo;
    wr && addr == {LDN_SMBUS, IDX_BASE_LO} |-> ##2 smbus_base[7:3] == $past(wdata[7:3], 2);
  endproperty
  a_base_lo: assert property (p_base_lo) else $error("base low");
  property p_base_hi;
    wr && addr == {LDN_SMBUS, IDX_BASE_HI} |-> ##2 smbus_base[11:8] == $past(wdata[3:0], 2);
  endproperty
  a_base_hi: assert property (p_base_hi) else $error("base high");
  c_rsvd: cover property (rd && addr == {LDN_KBD, 8'hFF});
  c_irq: cover property ($rose(irq));
  c_clk: cover property ($fell(key_wake_clk_en));
endmodule : ldcfg_bank_monitor

bind ldcfg_bank ldcfg_bank_monitor i_ldcfg_bank_monitor (.mclk(mclk), .rst_b(rst_b),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .alt_ctrl_port_en(alt_ctrl_port_en), .slow_clock_absent(slow_clock_absent),
  .key_wake_logic_off(key_wake_logic_off), .key_wake_clk_en(key_wake_clk_en),
  .smbus_base(smbus_base), .irq(irq));

// ===== testbench/ldcfg_bank_test.sv
// Self-checking testbench of the configuration bank.
module ldcfg_bank_test
  import ldcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0]        wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              kl = 1'b0, ki = 1'b0, mi = 1'b0, sc = 1'b0, sp = 1'b0, p0 = 1'b0, p1 = 1'b0;
  logic [7:0]        rdata;
  logic              kpo, kirq, mirq, alt, absn, koff, kclk, d0, d1, irq, rd_d = 1'b0;
  logic [15:0]       base;
  logic [7:0]        exp_q[$];
  logic [7:0]        wv[5];
  logic [15:0]       ra[5] = '{{LDN_KBD, IDX_F0}, {LDN_RUNTIME, IDX_F0}, {LDN_RUNTIME, IDX_F1},
                               {LDN_SMBUS, IDX_BASE_HI}, {LDN_SMBUS, IDX_BASE_LO}};
  logic [7:0]        rm[5] = '{KBD_MASK, CLK_MASK, STEER_MASK, BASE_HI_MASK, BASE_LO_MASK};
  int                err_count = 0;
  int                checked = 0;
  int                seed = 91;
  always #4 mclk = ~mclk;
  ldcfg_bank i_ldcfg_bank (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .kbc_port_line_raw(kl), .kbd_irq_raw(ki), .mouse_irq_raw(mi),
    .kbc_port_output_line(kpo), .kbd_irq(kirq), .mouse_irq(mirq), .alt_ctrl_port_en(alt),
    .slow_clock_in(sc), .slow_clock_absent(absn), .key_wake_logic_off(koff),
    .key_wake_clk_en(kclk), .steer_pin(sp), .pp_mode_floppy_d0(p0), .pp_mode_floppy_d1(p1),
    .drive0_on_pp(d0), .drive1_on_pp(d1), .smbus_base(base), .irq(irq));
  task automatic stop_test;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic chk(string name, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic wr_reg(logic [15:0] a, logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [15:0] a, logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd <= 1'b0;
  endtask : rd_reg
  // Pins cross a synchroniser, so levels are judged only after it has settled.
  task automatic settle;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  always @(posedge mclk) rd_d <= rd;
  always @(negedge mclk) begin
    if (rd_d)
      chk("rdata", exp_q.pop_front(), rdata);
  end
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chk("kbc_port_output_line", 1, kpo);
    for (int i = 0; i < 5; i++) rd_reg(ra[i], 8'h00);
    wr_reg({LDN_LOCAL, IDX_MASK}, 8'h01);
    ki <= 1'b1;
    settle();
    chk("irq", 1, irq);
    rd_reg({LDN_LOCAL, IDX_STATUS}, 8'h01);
    settle();
    chk("irq", 0, irq);
    wr_reg({LDN_LOCAL, IDX_MASK}, 8'h00);
    ki <= 1'b0;
    settle();
    @(posedge mclk);
    ki <= 1'b1;
    settle();
    chk("irq", 0, irq);
    rd_reg({LDN_LOCAL, IDX_STATUS}, 8'h01);
    for (int i = 0; i < 5; i++) begin
      wv[i] = 8'($random(seed));
      if (i == 3 && wv[i][3:0] == 4'h0) begin
        wv[i][0] = 1'b1;
      end
      wr_reg(ra[i], wv[i]);
      rd_reg(ra[i], wv[i] & rm[i]);
    end
    settle();
    chk("smbus_base", {4'h0, wv[3][3:0], wv[4][7:3], 3'h0}, base);
    wr_reg({LDN_KBD, IDX_F0}, 8'h63);
    rd_reg({LDN_KBD, IDX_F0}, 8'h00);
    rd_reg({LDN_KBD, 8'hF1}, 8'h00);
    rd_reg({LDN_KBD, 8'hFF}, 8'h00);
    wr_reg(16'h0150, 8'hFF);
    rd_reg(16'h0150, 8'h00);
    for (int p = 0; p < 2; p++) for (int l = 0; l < 2; l++) begin
      wr_reg({LDN_KBD, IDX_F0}, 8'(p * 128));
      kl <= 1'(l);
      settle();
      chk("kbc_port_output_line", p ? l : !l, kpo);
    end
    for (int s = 0; s < 2; s++) for (int v = 0; v < 2; v++) begin
      wr_reg({LDN_KBD, IDX_F0}, 8'(s * 8'h18 + v * 4));
      ki <= 1'(v);
      mi <= 1'(v);
      settle();
      chk("kbd_irq", v, kirq);
      chk("mouse_irq", v, mirq);
      chk("alt_ctrl_port_en", v, alt);
    end
    for (int k = 0; k < 4; k++) begin
      wr_reg({LDN_RUNTIME, IDX_F0}, 8'(k));
      sc <= 1'b1;
      settle();
      chk("slow_clock_absent", k % 2, absn);
      chk("key_wake_logic_off", k / 2, koff);
      chk("key_wake_clk_en", k == 0, kclk);
    end
    for (int f = 0; f < 4; f++) for (int p = 0; p < 2; p++) begin
      wr_reg({LDN_RUNTIME, IDX_F1}, 8'(f));
      sp <= 1'(p);
      p0 <= 1'($random(seed));
      p1 <= 1'($random(seed));
      settle();
      if (f == 1 || f == 2) begin
        if (p == 0) begin
          chk("drive0_on_pp", f == 2, d0);
          chk("drive1_on_pp", 1, d1);
        end else begin
          chk("drive0_on_pp", 0, d0);
          chk("drive1_on_pp", 0, d1);
        end
      end else begin
        chk("drive0_on_pp", p0, d0);
        chk("drive1_on_pp", p1, d1);
      end
    end
    stop_test();
  end
endmodule : ldcfg_bank_test
